// ==== rtl/btbd_pkg.sv ====
// constants, types and field layout for the branch / bit-modify / background slice
package btbd_pkg;
    typedef logic [15:0] btbd_word_t;
    typedef logic [31:0] btbd_long_t;
    typedef logic [4:0]  btbd_flags_t;

    // flag positions in the status word low byte
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;

    // opcode decode
    localparam logic [3:0]  BR_PREFIX     = 4'h6;
    localparam logic [3:0]  COND_NEVER    = 4'h1;
    localparam logic [7:0]  DISP_WORD     = 8'h00;
    localparam logic [7:0]  DISP_LONG     = 8'hff;
    localparam logic [7:0]  BIT_STATIC_HI = 8'h08;
    localparam logic [3:0]  BIT_DYN_HI    = 4'h0;
    localparam logic [7:0]  IMM_HI_ZERO   = 8'h00;
    localparam logic [1:0]  SEL_INVERT    = 2'h1;
    localparam logic [1:0]  SEL_CLEAR     = 2'h2;
    localparam logic [15:0] BG_ENTER_OP   = 16'h4afa;
    localparam logic [2:0]  MODE_DREG     = 3'h0;
    localparam logic [2:0]  MODE_IND_LO   = 3'h2;
    localparam logic [2:0]  MODE_IND_HI   = 3'h6;
    localparam logic [2:0]  MODE_EXT      = 3'h7;
    localparam logic [2:0]  EXT_ABS_LONG  = 3'h1;

    // bit numbering
    localparam int          LONG_NUM_W    = 5;
    localparam int          BYTE_NUM_W    = 3;
    localparam logic [31:0] BIT_ONE       = 32'h0000_0001;

    localparam logic [31:0] PC_STEP       = 32'h0000_0002;
    localparam logic [7:0]  ILLEGAL_VEC   = 8'h04;
    localparam logic [3:0]  FRAME_FORMAT  = 4'h0;

    // register map
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_MASK      = 4'h8;
    localparam logic [3:0]  REG_STATE     = 4'hc;
    localparam int          CTRL_BG_EN    = 0;
    localparam int          EV_W          = 4;
    localparam int          EV_BRANCH     = 0;
    localparam int          EV_ILLEGAL    = 1;
    localparam int          EV_FREEZE     = 2;
    localparam int          EV_BITOP      = 3;
endpackage

// ==== rtl/btbd_bit_if.sv ====
// carrier between the sequencer and the bit test-and-modify datapath
`timescale 1ns/1ps
interface btbd_bit_if;
    logic [31:0] operand;
    logic [7:0]  bitnum;
    logic        is_long;
    logic        invert;
    logic [31:0] result;
    logic        tested_zero;

    modport core (output operand, bitnum, is_long, invert, input result, tested_zero);
    modport unit (input operand, bitnum, is_long, invert, output result, tested_zero);
endinterface

// ==== rtl/btbd_bit_unit.sv ====
// combinational bit test with invert or clear of the addressed bit
`timescale 1ns/1ps
module btbd_bit_unit (
    btbd_bit_if.unit bus
);
    import btbd_pkg::*;

    wire [LONG_NUM_W-1:0] idx;
    wire [31:0]           mask;

    assign idx  = bus.is_long ? bus.bitnum[LONG_NUM_W-1:0]
                              : {{(LONG_NUM_W-BYTE_NUM_W){1'b0}}, bus.bitnum[BYTE_NUM_W-1:0]};
    assign mask = BIT_ONE << idx;
    assign bus.tested_zero = ~|(bus.operand & mask);
    assign bus.result = bus.invert ? (bus.operand ^ mask)
                                   : (bus.operand & ~mask);
endmodule

// ==== rtl/btbd_cond.sv ====
// condition field evaluation against the flags
`timescale 1ns/1ps
module btbd_cond (
    input  wire logic [3:0]          cond,
    input  wire btbd_pkg::btbd_flags_t flags,
    output logic                     is_true
);
    import btbd_pkg::*;

    wire n;
    wire z;
    wire v;
    wire c;
    assign n = flags[FLAG_N];
    assign z = flags[FLAG_Z];
    assign v = flags[FLAG_V];
    assign c = flags[FLAG_C];

    always_comb begin
        unique case (cond)
            4'h0: is_true = 1'b1;
            4'h1: is_true = 1'b0;
            4'h2: is_true = ~c & ~z;
            4'h3: is_true = c | z;
            4'h4: is_true = ~c;
            4'h5: is_true = c;
            4'h6: is_true = ~z;
            4'h7: is_true = z;
            4'h8: is_true = ~v;
            4'h9: is_true = v;
            4'ha: is_true = ~n;
            4'hb: is_true = n;
            4'hc: is_true = ~(n ^ v);
            4'hd: is_true = n ^ v;
            4'he: is_true = ~(n ^ v) & ~z;
            4'hf: is_true = z | (n ^ v);
        endcase
    end
endmodule

// ==== rtl/btbd_core.sv ====
// sequencer for conditional branch, bit invert/clear and background entry
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module btbd_core #(
    parameter logic [7:0] ILL_VECTOR = btbd_pkg::ILLEGAL_VEC
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    // instruction hand-in
    input  wire logic                   instr_valid,
    input  wire btbd_pkg::btbd_word_t   instr_word,
    input  wire btbd_pkg::btbd_long_t   instr_pc,
    output logic                        instr_ready,
    output logic                        done,
    // extension word fetch
    output logic                        ext_req,
    input  wire logic                   ext_valid,
    input  wire btbd_pkg::btbd_word_t   ext_word,
    // status word (flags in the low bits)
    input  wire btbd_pkg::btbd_word_t   status_word,
    output logic                        flags_we,
    output btbd_pkg::btbd_flags_t       flags_wdata,
    // data register file
    output logic [2:0]                  dreg_rd_addr,
    input  wire btbd_pkg::btbd_long_t   dreg_rd_data,
    output logic                        dreg_we,
    output logic [2:0]                  dreg_waddr,
    output btbd_pkg::btbd_long_t        dreg_wdata,
    // memory byte operand, address formed outside from mode/register
    output logic [2:0]                  ea_mode,
    output logic [2:0]                  ea_reg,
    output logic                        mem_req,
    output logic                        mem_we,
    output logic [7:0]                  mem_wdata,
    input  wire logic                   mem_ack,
    input  wire logic [7:0]             mem_rdata,
    // program counter load
    output logic                        pc_we,
    output btbd_pkg::btbd_long_t        pc_wdata,
    // background mode
    output logic                        freeze,
    input  wire logic                   bg_exit,
    // exception stacking on the supervisor stack
    output logic                        push_req,
    output btbd_pkg::btbd_long_t        push_data,
    input  wire logic                   push_ack,
    output logic                        vec_req,
    output logic [7:0]                  vec_num,
    input  wire logic                   vec_ack,
    input  wire btbd_pkg::btbd_long_t   vec_data,
    // register port
    input  wire logic [3:0]             reg_addr,
    input  wire btbd_pkg::btbd_long_t   reg_wdata,
    input  wire logic                   reg_we,
    input  wire logic                   reg_re,
    output btbd_pkg::btbd_long_t        reg_rdata,
    output logic                        irq
);
    import btbd_pkg::*;

    if (ILL_VECTOR == 8'h00) begin : g_chk
        $error("illegal-instruction vector must be nonzero");
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_EXT_FIRST, ST_EXT_SECOND, ST_BIT_IMM, ST_BIT_NUM,
        ST_BIT_DREG, ST_MEM_RD, ST_MEM_WR, ST_FREEZE, ST_PUSH, ST_VECTOR
    } btbd_state_e;

    btbd_state_e      state;
    btbd_state_e      next_state;
    logic [15:0]      opcode;
    logic [31:0]      op_pc;
    logic [15:0]      disp_hi;
    logic             long_disp;
    logic             taken;
    logic [7:0]       bitnum;
    logic [1:0]       push_idx;
    logic             bg_enable;
    logic [EV_W-1:0]  ev_status;
    logic [EV_W-1:0]  ev_mask;

    btbd_bit_if bit_bus ();

    // decode of the word being handed in
    wire [7:0]  in_disp8;
    wire [2:0]  in_mode;
    wire [2:0]  in_reg;
    wire [1:0]  in_sel;
    wire        in_sel_ok;
    wire        in_ea_ok;
    wire        in_branch;
    wire        in_bit_static;
    wire        in_bit_dyn;
    wire        in_bg_enter;
    wire        in_cond_true;
    wire        accept;

    assign in_disp8  = instr_word[7:0];
    assign in_mode   = instr_word[5:3];
    assign in_reg    = instr_word[2:0];
    assign in_sel    = instr_word[7:6];
    assign in_sel_ok = (in_sel == SEL_INVERT) || (in_sel == SEL_CLEAR);
    assign in_ea_ok  = (in_mode == MODE_DREG)
                     || (in_mode >= MODE_IND_LO && in_mode <= MODE_IND_HI)
                     || (in_mode == MODE_EXT && in_reg <= EXT_ABS_LONG);
    assign in_branch     = (instr_word[15:12] == BR_PREFIX) && (instr_word[11:8] > COND_NEVER);
    assign in_bit_static = (instr_word[15:8] == BIT_STATIC_HI) && in_sel_ok;
    assign in_bit_dyn    = (instr_word[15:12] == BIT_DYN_HI) && instr_word[8] && in_sel_ok;
    assign in_bg_enter   = (instr_word == BG_ENTER_OP);
    assign accept        = instr_valid && (state == ST_IDLE);

    btbd_cond u_cond (
        .cond    (instr_word[11:8]),
        .flags   (status_word[4:0]),
        .is_true (in_cond_true)
    );

    // branch target: base is always the opcode address plus two
    wire [31:0] base_pc;
    wire [31:0] disp_sel;
    wire [31:0] target;
    wire        br_finish;
    wire        br_taken_now;

    assign base_pc  = ((state == ST_IDLE) ? instr_pc : op_pc) + PC_STEP;
    assign disp_sel = (state == ST_IDLE)      ? {{24{in_disp8[7]}}, in_disp8}
                    : (state == ST_EXT_SECOND) ? {disp_hi, ext_word}
                    : {{16{ext_word[15]}}, ext_word};
    assign target   = base_pc + disp_sel;
    assign br_finish = (accept && in_branch && in_disp8 != DISP_WORD && in_disp8 != DISP_LONG)
                     || (state == ST_EXT_FIRST && ext_valid && !long_disp)
                     || (state == ST_EXT_SECOND && ext_valid);
    assign br_taken_now = (state == ST_IDLE) ? in_cond_true : taken;

    // bit datapath hookup
    wire dest_is_dreg;
    wire [2:0] num_reg;
    assign dest_is_dreg = (opcode[5:3] == MODE_DREG);
    assign num_reg      = opcode[11:9];
    assign bit_bus.operand = (state == ST_BIT_DREG) ? dreg_rd_data : {24'h00_0000, mem_rdata};
    assign bit_bus.bitnum  = bitnum;
    assign bit_bus.is_long = (state == ST_BIT_DREG);
    assign bit_bus.invert  = (opcode[7:6] == SEL_INVERT);

    btbd_bit_unit u_bit (
        .bus (bit_bus)
    );

    wire bit_finish;
    wire illegal_go;
    wire imm_bad;
    assign bit_finish = (state == ST_BIT_DREG) || (state == ST_MEM_WR && mem_ack);
    assign imm_bad    = (state == ST_BIT_IMM) && ext_valid && (ext_word[15:8] != IMM_HI_ZERO);
    assign illegal_go = (accept && (in_bit_static || in_bit_dyn) && !in_ea_ok)
                      || (accept && in_bg_enter && !bg_enable)
                      || imm_bad;

    // handshake outputs from state
    assign instr_ready  = (state == ST_IDLE);
    assign ext_req      = (state == ST_EXT_FIRST) || (state == ST_EXT_SECOND)
                        || (state == ST_BIT_IMM);
    assign dreg_rd_addr = (state == ST_BIT_NUM) ? num_reg : opcode[2:0];
    assign ea_mode      = opcode[5:3];
    assign ea_reg       = opcode[2:0];
    assign mem_req      = (state == ST_MEM_RD) || (state == ST_MEM_WR);
    assign mem_we       = (state == ST_MEM_WR);
    assign push_req     = (state == ST_PUSH);
    assign vec_req      = (state == ST_VECTOR);
    assign vec_num      = ILL_VECTOR;
    assign irq          = |(ev_status & ev_mask);

    wire btbd_state_e bit_dest;
    assign bit_dest = dest_is_dreg ? ST_BIT_DREG : ST_MEM_RD;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (illegal_go) begin
                    next_state = ST_PUSH;
                end else if (accept && in_branch && in_disp8 == DISP_WORD) begin
                    next_state = ST_EXT_FIRST;
                end else if (accept && in_branch && in_disp8 == DISP_LONG) begin
                    next_state = ST_EXT_FIRST;
                end else if (accept && in_bit_static) begin
                    next_state = ST_BIT_IMM;
                end else if (accept && in_bit_dyn) begin
                    next_state = ST_BIT_NUM;
                end else if (accept && in_bg_enter) begin
                    next_state = ST_FREEZE;
                end
            end
            ST_EXT_FIRST: begin
                if (ext_valid) begin
                    next_state = long_disp ? ST_EXT_SECOND : ST_IDLE;
                end
            end
            ST_EXT_SECOND: begin
                if (ext_valid) begin
                    next_state = ST_IDLE;
                end
            end
            ST_BIT_IMM: begin
                if (imm_bad) begin
                    next_state = ST_PUSH;
                end else if (ext_valid) begin
                    next_state = bit_dest;
                end
            end
            ST_BIT_NUM:  next_state = bit_dest;
            ST_BIT_DREG: next_state = ST_IDLE;
            ST_MEM_RD: begin
                if (mem_ack) begin
                    next_state = ST_MEM_WR;
                end
            end
            ST_MEM_WR: begin
                if (mem_ack) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FREEZE: begin
                if (bg_exit) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PUSH: begin
                if (push_ack && push_idx == 2'd2) begin
                    next_state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                if (vec_ack) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // instruction capture and operand latches
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            opcode    <= 16'h0000;
            op_pc     <= 32'h0000_0000;
            long_disp <= 1'b0;
            taken     <= 1'b0;
            disp_hi   <= 16'h0000;
            bitnum    <= 8'h00;
            mem_wdata <= 8'h00;
        end else begin
            if (accept) begin
                opcode    <= instr_word;
                op_pc     <= instr_pc;
                long_disp <= (in_disp8 == DISP_LONG);
                taken     <= in_cond_true;
            end
            if (state == ST_EXT_FIRST && ext_valid) begin
                disp_hi <= ext_word;
            end
            if (state == ST_BIT_IMM && ext_valid) begin
                bitnum <= ext_word[7:0];
            end
            if (state == ST_BIT_NUM) begin
                bitnum <= dreg_rd_data[7:0];
            end
            if (state == ST_MEM_RD && mem_ack) begin
                mem_wdata <= bit_bus.result[7:0];
            end
        end
    end

    // zero flag of the memory form is sampled at the read
    logic mem_zero;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_zero <= 1'b0;
        end else if (state == ST_MEM_RD && mem_ack) begin
            mem_zero <= bit_bus.tested_zero;
        end
    end

    // result strobes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done        <= 1'b0;
            pc_we       <= 1'b0;
            pc_wdata    <= 32'h0000_0000;
            dreg_we     <= 1'b0;
            dreg_waddr  <= 3'h0;
            dreg_wdata  <= 32'h0000_0000;
            flags_we    <= 1'b0;
            flags_wdata <= 5'h00;
        end else begin
            done     <= br_finish || bit_finish || (state == ST_FREEZE && bg_exit)
                     || (state == ST_VECTOR && vec_ack);
            pc_we    <= (br_finish && br_taken_now) || (state == ST_VECTOR && vec_ack);
            pc_wdata <= (state == ST_VECTOR) ? vec_data : target;
            dreg_we  <= (state == ST_BIT_DREG);
            flags_we <= bit_finish;
            if (state == ST_BIT_DREG) begin
                dreg_waddr <= opcode[2:0];
                dreg_wdata <= bit_bus.result;
            end
            if (bit_finish) begin
                flags_wdata         <= status_word[4:0];
                flags_wdata[FLAG_Z] <= (state == ST_BIT_DREG) ? bit_bus.tested_zero : mem_zero;
            end
        end
    end

    // exception frame: format/vector word, then counter, then status word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            push_idx  <= 2'd0;
            push_data <= 32'h0000_0000;
        end else if (state != ST_PUSH && next_state == ST_PUSH) begin
            push_idx  <= 2'd0;
            push_data <= {16'h0000, FRAME_FORMAT, 2'b00, ILL_VECTOR, 2'b00};
        end else if (state == ST_PUSH && push_ack) begin
            push_idx  <= push_idx + 2'd1;
            push_data <= (push_idx == 2'd0) ? op_pc : {16'h0000, status_word};
        end
    end

    // freeze acknowledge, flags untouched in this path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            freeze <= 1'b0;
        end else if (accept && in_bg_enter && bg_enable) begin
            freeze <= 1'b1;
        end else if (state == ST_FREEZE && bg_exit) begin
            freeze <= 1'b0;
        end
    end

    // register port and event bits
    wire [EV_W-1:0] ev_set;
    wire            sel_ctrl;
    wire            sel_status;
    wire            sel_mask;
    wire            sel_state;
    wire [31:0]     rd_mux;

    assign ev_set[EV_BRANCH]  = br_finish && br_taken_now;
    assign ev_set[EV_ILLEGAL] = illegal_go;
    assign ev_set[EV_FREEZE]  = accept && in_bg_enter && bg_enable;
    assign ev_set[EV_BITOP]   = bit_finish;
    assign sel_ctrl   = (reg_addr == REG_CTRL);
    assign sel_status = (reg_addr == REG_STATUS);
    assign sel_mask   = (reg_addr == REG_MASK);
    assign sel_state  = (reg_addr == REG_STATE);
    assign rd_mux = sel_ctrl   ? {31'h0000_0000, bg_enable}
                  : sel_status ? {{(32-EV_W){1'b0}}, ev_status}
                  : sel_mask   ? {{(32-EV_W){1'b0}}, ev_mask}
                  : sel_state  ? {28'h000_0000, state}
                  : 32'h0000_0000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bg_enable <= 1'b0;
            ev_mask   <= '0;
            ev_status <= '0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_we && sel_ctrl) begin
                bg_enable <= reg_wdata[CTRL_BG_EN];
            end
            if (reg_we && sel_mask) begin
                ev_mask <= reg_wdata[EV_W-1:0];
            end
            ev_status <= (ev_status & ~((reg_we && sel_status) ? reg_wdata[EV_W-1:0] : '0))
                       | ev_set;
            reg_rdata <= reg_re ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

// ==== tb/btbd_core_asserts.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module btbd_core_asserts #(
    parameter logic [7:0] ILL_VECTOR = 8'h04
) (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 instr_valid,
    input wire btbd_pkg::btbd_word_t instr_word,
    input wire btbd_pkg::btbd_long_t instr_pc,
    input wire logic                 instr_ready,
    input wire logic                 done,
    input wire logic                 ext_req,
    input wire btbd_pkg::btbd_word_t status_word,
    input wire logic                 flags_we,
    input wire btbd_pkg::btbd_flags_t flags_wdata,
    input wire logic                 pc_we,
    input wire btbd_pkg::btbd_long_t pc_wdata,
    input wire logic                 freeze,
    input wire logic                 bg_exit,
    input wire logic                 push_req,
    input wire btbd_pkg::btbd_long_t push_data,
    input wire logic                 vec_req,
    input wire logic                 vec_ack,
    input wire btbd_pkg::btbd_long_t vec_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // take of a decoded conditional branch
    wire br_take = instr_valid && instr_ready && instr_word[15:12] == 4'h6
                   && instr_word[11:9] != 3'h0;
    wire [7:0] d8 = instr_word[7:0];

    property p_short; br_take && d8 != 8'h00 && d8 != 8'hff |=> done && (!pc_we
        || pc_wdata == $past(instr_pc) + 32'h0000_0002 + {{24{$past(d8[7])}}, $past(d8)});
    endproperty
    a_short: assert property (p_short) else $error("short branch target wrong");
    property p_wordext; br_take && d8 == 8'h00 |=> ext_req && !done; endproperty
    a_wordext: assert property (p_wordext) else $error("no extension fetch");
    property p_flags; flags_we |-> {flags_wdata[4:3], flags_wdata[1:0]}
        == {status_word[4:3], status_word[1:0]}; endproperty
    a_flags: assert property (p_flags) else $error("flag other than zero changed");
    property p_hold; freeze && !bg_exit |=> freeze && !instr_ready; endproperty
    a_hold: assert property (p_hold) else $error("background left early");
    property p_resume; freeze && bg_exit |=> !freeze && done; endproperty
    a_resume: assert property (p_resume) else $error("background exit late");
    property p_bgflags; $fell(freeze) |-> !pc_we && !flags_we; endproperty
    a_bgflags: assert property (p_bgflags) else $error("background touched state");
    property p_vec; vec_req && vec_ack |=> done && pc_we && pc_wdata == $past(vec_data);
    endproperty
    a_vec: assert property (p_vec) else $error("vector not loaded");
    property p_frame; $rose(push_req) |-> push_data == {22'h0, ILL_VECTOR, 2'b00}; endproperty
    a_frame: assert property (p_frame) else $error("frame word wrong");
endmodule

bind btbd_core btbd_core_asserts #(.ILL_VECTOR(ILL_VECTOR)) u_btbd_chk (.clk, .reset,
    .instr_valid, .instr_word, .instr_pc, .instr_ready, .done, .ext_req, .status_word,
    .flags_we, .flags_wdata, .pc_we, .pc_wdata, .freeze, .bg_exit, .push_req, .push_data,
    .vec_req, .vec_ack, .vec_data);

// ==== tb/btbd_core_tb.sv ====
// self-checking bench for the branch / bit-modify / background sequencer
`timescale 1ns/1ps
module btbd_core_tb;
    import btbd_pkg::*;
    logic        clk = 0, reset = 1, instr_valid = 0, ext_valid = 0, mem_ack = 0, fz;
    logic        bg_exit = 0, push_ack = 0, vec_ack = 0, reg_we = 0, reg_re = 0;
    logic        instr_ready, done, ext_req, flags_we, dreg_we, mem_req, mem_we, pc_we;
    logic        freeze, push_req, vec_req, irq;
    logic [1:0]  ei = 0, pn = 0;
    logic [2:0]  dreg_rd_addr, dreg_waddr, ea_mode, ea_reg, n, r, m;
    logic [3:0]  reg_addr = 0, c;
    logic [4:0]  flags_wdata, b;
    logic [7:0]  mem_wdata, vec_num, mem_rdata = 0, wb, d;
    logic [15:0] instr_word = 0, status_word = 0, ext_q [4];
    logic [31:0] instr_pc = 0, vec_data = 0, reg_wdata = 0, pc_wdata, dreg_wdata, push_data;
    logic [31:0] reg_rdata, rv, pc, dr [8], pd [4];
    logic [5:0]  bad [5] = '{6'h08, 6'h3c, 6'h3a, 6'h3b, 6'h00};
    int          failures = 0, compares = 0, k;
    wire [15:0]  ext_word = ext_q[ei];
    wire [31:0]  dreg_rd_data = dr[dreg_rd_addr];

    btbd_core uut (.clk, .reset, .instr_valid, .instr_word, .instr_pc, .instr_ready, .done,
        .ext_req, .ext_valid, .ext_word, .status_word, .flags_we, .flags_wdata, .dreg_rd_addr,
        .dreg_rd_data, .dreg_we, .dreg_waddr, .dreg_wdata, .ea_mode, .ea_reg, .mem_req,
        .mem_we, .mem_wdata, .mem_ack, .mem_rdata, .pc_we, .pc_wdata, .freeze, .bg_exit,
        .push_req, .push_data, .push_ack, .vec_req, .vec_num, .vec_ack, .vec_data, .reg_addr,
        .reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq);

    always #50 clk = ~clk;
    // far-side responders: one answer per request, a cycle late
    always @(posedge clk) begin
        ext_valid <= ext_req && !ext_valid;
        mem_ack <= mem_req && !mem_ack;
        push_ack <= push_req && !push_ack;
        vec_ack <= vec_req && !vec_ack;
        bg_exit <= freeze && !bg_exit;
        if (ext_valid) ei <= ei + 2'h1;
        if (mem_ack && mem_we) wb <= mem_wdata;
        if (push_ack) begin
            pd[pn] <= push_data;
            pn <= pn + 2'h1;
        end
    end

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic ctrue(input logic [3:0] cc, input logic [4:0] f);
        logic t;
        case (cc[3:1])
            3'h1: t = !f[0] && !f[2];
            3'h2: t = !f[0];
            3'h3: t = !f[2];
            3'h4: t = !f[1];
            3'h5: t = !f[3];
            3'h6: t = f[3] == f[1];
            default: t = f[3] == f[1] && !f[2];
        endcase
        return t ^ cc[0];
    endfunction
    task automatic run(input logic [15:0] w);
        int i;
        @(posedge clk);
        instr_valid <= 1;
        instr_word <= w;
        instr_pc <= pc;
        ei <= 0;
        pn <= 0;
        fz = 0;
        @(posedge clk);
        instr_valid <= 0;
        #1;
        for (i = 0; i < 60 && done !== 1'b1; i++) begin
            @(posedge clk) #1;
            fz |= freeze;
        end
        if (i == 60) begin
            failures++;
            test_done();
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge clk);
        reg_we <= 1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_we <= 0;
        #1;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clk);
        reg_re <= 1;
        reg_addr <= ad;
        @(posedge clk);
        reg_re <= 0;
        #1 rv = reg_rdata;
    endtask
    initial begin
        void'($urandom(77));
        repeat (3) @(posedge clk);
        reset <= 0;
        pc = 32'h0000_1000;
        status_word <= 16'h0015;
        vec_data <= $urandom;
        run(BG_ENTER_OP);
        chk(pc_wdata, vec_data);
        chk(pd[1], pc);
        chk(pd[2], {16'h0, status_word});
        wr(REG_CTRL, 32'h0000_0001);
        rd(REG_CTRL);
        chk(rv, 32'h0000_0001);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2);
        chk(rv, 32'h0000_0000);
        run(BG_ENTER_OP);
        chk(fz, 1);
        chk(pc_we, 0);
        chk(flags_we, 0);
        $display("background test finished");
        repeat (24) begin
            c = 4'($urandom_range(15, 2));
            d = 8'($urandom_range(254, 1));
            status_word <= 16'($urandom_range(31));
            pc = $urandom & 32'hffff_fffe;
            run({4'h6, c, d});
            chk(pc_we, ctrue(c, status_word[4:0]));
            if (ctrue(c, status_word[4:0])) chk(pc_wdata, pc + PC_STEP + {{24{d[7]}}, d});
        end
        status_word <= 16'h001a;
        ext_q[0] = 16'($urandom);
        ext_q[1] = 16'($urandom);
        run(16'h6400);
        chk(pc_wdata, pc + PC_STEP + {{16{ext_q[0][15]}}, ext_q[0]});
        run(16'h64ff);
        chk(pc_wdata, pc + PC_STEP + {ext_q[0], ext_q[1]});
        $display("branch test finished");
        for (k = 1; k < 3; k++) repeat (8) begin
            foreach (dr[j]) dr[j] = $urandom;
            n = 3'($urandom);
            r = 3'($urandom);
            m = 3'($urandom_range(6, 2));
            b = dr[n][4:0];
            run({4'h0, n, 1'b1, 2'(k), 3'h0, r});
            chk(dreg_waddr, r);
            chk(dreg_wdata, k == 1 ? dr[r] ^ (BIT_ONE << b) : dr[r] & ~(BIT_ONE << b));
            chk(flags_wdata[2], !dr[r][b]);
            mem_rdata <= 8'($urandom);
            ext_q[0] = {8'h00, 8'($urandom)};
            run({8'h08, 2'(k), m, r});
            chk(ea_mode, m);
            d = 8'h01 << ext_q[0][2:0];
            chk(wb, k == 1 ? mem_rdata ^ d : mem_rdata & ~d);
            chk(flags_wdata[2], !mem_rdata[ext_q[0][2:0]]);
        end
        ext_q[0] = 16'hff00;
        foreach (bad[j]) begin
            run({8'h08, 2'h2, bad[j]});
            chk(pc_wdata, vec_data);
        end
        $display("bit operation test finished");
        wr(REG_MASK, 32'h0000_0000);
        chk(irq, 0);
        wr(REG_MASK, 32'h0000_000f);
        chk(irq, 1);
        wr(REG_STATUS, 32'h0000_000f);
        chk(irq, 0);
        rd(REG_STATUS);
        chk(rv, 32'h0000_0000);
        $display("interrupt test finished");
        test_done();
    end
endmodule
